// >>> design/scr_cfg.svh
// Offsets, field positions, reset values and codes of the control bank
`ifndef SCR_CFG_SVH
`define SCR_CFG_SVH
`define SCR_AW            5
`define SCR_OFF_SYSCTL    5'h09
`define SCR_OFF_RSVD_A    5'h0A
`define SCR_OFF_OFS_LO    5'h0B
`define SCR_OFF_OFS_HI    5'h0C
`define SCR_OFF_RSVD_D    5'h0D
`define SCR_OFF_GAIN_LO   5'h0E
`define SCR_OFF_GAIN_HI   5'h0F
`define SCR_OFF_STATUS    5'h1F
`define SCR_RST_SYSCTL    8'h10
`define SCR_RST_RSVD      8'h00
`define SCR_RST_OFS_LO    8'h00
`define SCR_RST_OFS_HI    8'h00
`define SCR_RST_GAIN_LO   8'h00
`define SCR_RST_GAIN_HI   8'h40
`define SCR_MON_MSB       7
`define SCR_MON_LSB       5
`define SCR_SAMP_MSB      4
`define SCR_SAMP_LSB      3
`define SCR_TMO_BIT       2
`define SCR_RSVD_MASK     8'hFC
`define SCR_MON_OFF       3'h0
`define SCR_MON_SHORT     3'h1
`define SCR_MON_TEMP      3'h2
`define SCR_MON_ANALOG_SUPPLY_POS      3'h3
`define SCR_MON_DIGITAL_SUPPLY      3'h4
`define SCR_MON_BO_LO     3'h5
`define SCR_MON_BO_HI     3'h6
`define SCR_TEMP_MAX_GAIN 3'h2
`endif

// >>> design/scr_pkg.sv
// Types shared by the control and calibration bank
`default_nettype none
package scr_pkg;
  typedef struct packed {
    logic [2:0] monitor_select;
    logic [1:0] calib_sample_count;
    logic       timeout_en;
  } scr_cfg_t;

  typedef struct packed {
    logic [15:0] offset_correction_value;
    logic [15:0] gain_correction_value;
  } scr_cal_t;

  typedef struct packed {
    logic       mux_open;
    logic       gain_force_one;
    logic       temp_sense_en;
    logic       mid_short_en;
    logic [1:0] burnout_level;
    logic       temp_gain_bad;
  } scr_mon_t;
endpackage : scr_pkg
`default_nettype wire

// >>> design/scr_mon_decode.sv
// Monitor code decoder into analog front-end controls
`timescale 1ns/1ns
`default_nettype none
`include "scr_cfg.svh"
module scr_mon_decode
  import scr_pkg::*;
(
  // Selection
  input  wire logic [2:0] i_monitor_select,
  input  wire logic [2:0] i_gain_code,
  input  wire logic       i_amp_enabled,
  // Controls
  output scr_mon_t        o_mon
);
  always_comb begin
    o_mon = '0;
    case (i_monitor_select)
      `SCR_MON_OFF: begin
        o_mon = '0;
      end
      `SCR_MON_SHORT: begin
        o_mon.mid_short_en = 1'b1;
        o_mon.mux_open     = 1'b1;
      end
      `SCR_MON_TEMP: begin
        o_mon.temp_sense_en = 1'b1;
        o_mon.mux_open      = 1'b1;
        o_mon.temp_gain_bad = !i_amp_enabled ||
          (i_gain_code > `SCR_TEMP_MAX_GAIN);
      end
      `SCR_MON_ANALOG_SUPPLY_POS, `SCR_MON_DIGITAL_SUPPLY: begin
        o_mon.gain_force_one = 1'b1;
        o_mon.mux_open       = 1'b1;
      end
      `SCR_MON_BO_LO: begin
        o_mon.burnout_level = 2'h1;
      end
      `SCR_MON_BO_HI: begin
        o_mon.burnout_level = 2'h2;
      end
      default: begin
        o_mon = '0;
      end
    endcase
  end
endmodule : scr_mon_decode
`default_nettype wire

// >>> design/scr_cal_pair.sv
// Two-byte calibration value with coherent update
`timescale 1ns/1ns
`default_nettype none
module scr_cal_pair #(
  parameter logic [15:0] RST = 16'h0000
) (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rstn,
  // Byte writes
  input  wire logic        i_wr_lo,
  input  wire logic        i_wr_hi,
  input  wire logic [7:0]  i_wdata,
  // Values
  output logic      [15:0] o_bytes,
  output logic      [15:0] o_applied
);
  typedef struct packed {
    logic [15:0] bytes;
    logic [15:0] applied;
    logic        lo_new;
    logic        hi_new;
  } scr_pair_st_t;

  scr_pair_st_t st_ff;
  scr_pair_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (i_wr_lo) begin
      nxt_st.bytes[7:0] = i_wdata;
      nxt_st.lo_new     = 1'b1;
    end
    if (i_wr_hi) begin
      nxt_st.bytes[15:8] = i_wdata;
      nxt_st.hi_new      = 1'b1;
    end
    // Apply only once both halves were refreshed
    if (nxt_st.lo_new && nxt_st.hi_new) begin
      nxt_st.applied = nxt_st.bytes;
      nxt_st.lo_new  = 1'b0;
      nxt_st.hi_new  = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      st_ff <= '{bytes: RST, applied: RST, lo_new: 1'b0, hi_new: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_bytes   = st_ff.bytes;
  assign o_applied = st_ff.applied;
endmodule : scr_cal_pair
`default_nettype wire

// >>> design/scr_regs.sv
// System control and calibration register bank
`timescale 1ns/1ns
`default_nettype none
`include "scr_cfg.svh"

// Contract
// - Monitor select bits 7:5, reset 0; 000 off, 001 mid-supply short.
// - Code 010 routes temp sensor; host keeps amp on, gain at most 4.
// - Codes 011 and 100 force amplifier gain to 1.
// - Codes 101 and 110 enable burn-out sources; 101 is smaller.
// - Short, temperature and supply monitors open all input switches.
// - Sample count bits 4:3, reset 10; 1, 4, 8 or 16 conversions.
// - Timeout enable at bit 2, reset 0.
// - Offsets 0Ah and 0Dh read-only, read 00h; host writes 00h.
// - Offset low byte at 0Bh, reset 00h.
// - Offset high byte at 0Ch, reset 00h.
// - Gain low byte at 0Eh, reset 00h.
// - Gain high byte at 0Fh, reset 40h, value 4000h.
module scr_regs
  import scr_pkg::*;
(
  // Clock and reset
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_rstn,
  // Register port
  input  wire logic [`SCR_AW-1:0]   i_addr,
  input  wire logic [7:0]           i_wdata,
  input  wire logic                 i_wr,
  input  wire logic                 i_rd,
  output logic      [7:0]           o_rdata,
  // Converter side
  input  wire logic                 i_conv_start,
  input  wire logic [2:0]           i_gain_code,
  input  wire logic                 i_amp_enabled,
  output scr_cfg_t                  o_cfg,
  output scr_mon_t                  o_mon,
  output logic      [4:0]           o_calib_samples,
  output scr_cal_t                  o_cal
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] sysctl;
    logic [7:0] rdata;
    scr_cfg_t   cfg;
    scr_mon_t   mon;
    logic [4:0] samples;
    scr_cal_t   cal;
    logic       rsvd_wr_err;
  } scr_st_t;

  scr_st_t    st_ff;
  scr_st_t    nxt_st;
  logic [15:0] ofs_bytes;
  logic [15:0] ofs_applied;
  logic [15:0] gain_bytes;
  logic [15:0] gain_applied;
  scr_mon_t   mon_dec;
  logic [2:0]  mon_next;

  function automatic logic [4:0] samp_count(input logic [1:0] code);
    case (code)
      2'h0:    samp_count = 5'h01;
      2'h1:    samp_count = 5'h04;
      2'h2:    samp_count = 5'h08;
      default: samp_count = 5'h10;
    endcase
  endfunction : samp_count

  function automatic logic hit(input logic [`SCR_AW-1:0] a,
                               input logic [`SCR_AW-1:0] off);
    hit = (a == off);
  endfunction : hit

  // ----------------------------------------------------------------
  // Calibration pairs
  // ----------------------------------------------------------------
  scr_cal_pair #(
    .RST ({`SCR_RST_OFS_HI, `SCR_RST_OFS_LO})
  ) u_ofs (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_wr_lo   (i_wr && hit(i_addr, `SCR_OFF_OFS_LO)),
    .i_wr_hi   (i_wr && hit(i_addr, `SCR_OFF_OFS_HI)),
    .i_wdata   (i_wdata),
    .o_bytes   (ofs_bytes),
    .o_applied (ofs_applied)
  );

  scr_cal_pair #(
    .RST ({`SCR_RST_GAIN_HI, `SCR_RST_GAIN_LO})
  ) u_gain (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_wr_lo   (i_wr && hit(i_addr, `SCR_OFF_GAIN_LO)),
    .i_wr_hi   (i_wr && hit(i_addr, `SCR_OFF_GAIN_HI)),
    .i_wdata   (i_wdata),
    .o_bytes   (gain_bytes),
    .o_applied (gain_applied)
  );

  // ----------------------------------------------------------------
  // Monitor decode of the latched setting
  // ----------------------------------------------------------------
  // Select seen by the converter after this edge, kept off nxt_st
  always_comb begin
    mon_next = st_ff.cfg.monitor_select;
    if (i_conv_start) begin
      mon_next = st_ff.sysctl[`SCR_MON_MSB:`SCR_MON_LSB];
    end
  end

  scr_mon_decode u_mon (
    .i_monitor_select (mon_next),
    .i_gain_code      (i_gain_code),
    .i_amp_enabled    (i_amp_enabled),
    .o_mon            (mon_dec)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.rdata = 8'h00;
    if (i_wr && hit(i_addr, `SCR_OFF_SYSCTL)) begin
      nxt_st.sysctl = i_wdata;
      // Flag a host that breaks the reserved-bit convention
      if ((i_wdata & ~`SCR_RSVD_MASK) != 8'h00) begin
        nxt_st.rsvd_wr_err = 1'b1;
      end
    end
    if (i_wr && (hit(i_addr, `SCR_OFF_RSVD_A) ||
                 hit(i_addr, `SCR_OFF_RSVD_D)) &&
        (i_wdata != 8'h00)) begin
      nxt_st.rsvd_wr_err = 1'b1;
    end
    // Settings copied to the converter at a start
    if (i_conv_start) begin
      nxt_st.cfg.monitor_select =
        st_ff.sysctl[`SCR_MON_MSB:`SCR_MON_LSB];
      nxt_st.cfg.calib_sample_count =
        st_ff.sysctl[`SCR_SAMP_MSB:`SCR_SAMP_LSB];
      nxt_st.cfg.timeout_en = st_ff.sysctl[`SCR_TMO_BIT];
    end
    nxt_st.mon     = mon_dec;
    nxt_st.samples = samp_count(nxt_st.cfg.calib_sample_count);
    nxt_st.cal.offset_correction_value = ofs_applied;
    nxt_st.cal.gain_correction_value   = gain_applied;
    if (i_rd) begin
      case (i_addr)
        `SCR_OFF_SYSCTL:  nxt_st.rdata = st_ff.sysctl;
        `SCR_OFF_RSVD_A:  nxt_st.rdata = `SCR_RST_RSVD;
        `SCR_OFF_RSVD_D:  nxt_st.rdata = `SCR_RST_RSVD;
        `SCR_OFF_OFS_LO:  nxt_st.rdata = ofs_bytes[7:0];
        `SCR_OFF_OFS_HI:  nxt_st.rdata = ofs_bytes[15:8];
        `SCR_OFF_GAIN_LO: nxt_st.rdata = gain_bytes[7:0];
        `SCR_OFF_GAIN_HI: nxt_st.rdata = gain_bytes[15:8];
        `SCR_OFF_STATUS: begin
          nxt_st.rdata = {6'h00, st_ff.mon.temp_gain_bad,
                          st_ff.rsvd_wr_err};
          nxt_st.rsvd_wr_err = 1'b0;
        end
        default:          nxt_st.rdata = 8'h00;
      endcase
    end
    // Set wins over the read-clear
    if (i_wr && hit(i_addr, `SCR_OFF_SYSCTL) &&
        ((i_wdata & ~`SCR_RSVD_MASK) != 8'h00)) begin
      nxt_st.rsvd_wr_err = 1'b1;
    end
    if (i_wr && (hit(i_addr, `SCR_OFF_RSVD_A) ||
                 hit(i_addr, `SCR_OFF_RSVD_D)) &&
        (i_wdata != 8'h00)) begin
      nxt_st.rsvd_wr_err = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      st_ff.sysctl      <= `SCR_RST_SYSCTL;
      st_ff.rdata       <= 8'h00;
      st_ff.cfg         <= '{monitor_select: `SCR_MON_OFF,
                             calib_sample_count: 2'h2,
                             timeout_en: 1'b0};
      st_ff.mon         <= '0;
      st_ff.samples     <= 5'h08;
      st_ff.cal         <= '{offset_correction_value: 16'h0000,
                             gain_correction_value: 16'h4000};
      st_ff.rsvd_wr_err <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_rdata         = st_ff.rdata;
  assign o_cfg           = st_ff.cfg;
  assign o_mon           = st_ff.mon;
  assign o_calib_samples = st_ff.samples;
  assign o_cal           = st_ff.cal;
endmodule : scr_regs
`default_nettype wire

// >>> bench/scr_regs_monitor.sv
// Assertion checker for the control and calibration bank
`timescale 1ns/1ns
`default_nettype none
`include "scr_cfg.svh"
module scr_regs_monitor
  import scr_pkg::*;
(
  // Watched ports
  input wire logic                 i_clk_sys,
  input wire logic                 i_rstn,
  input wire logic [`SCR_AW-1:0]   i_addr,
  input wire logic [7:0]           i_wdata,
  input wire logic                 i_wr,
  input wire logic                 i_rd,
  input wire logic [7:0]           o_rdata,
  input wire logic                 i_conv_start,
  input wire logic [2:0]           i_gain_code,
  input wire logic                 i_amp_enabled,
  input wire scr_cfg_t             o_cfg,
  input wire scr_mon_t             o_mon,
  input wire logic [4:0]           o_calib_samples,
  input wire scr_cal_t             o_cal
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  wire [2:0] m = o_cfg.monitor_select;
  wire [1:0] c = o_cfg.calib_sample_count;

  a_rsvd_read: assert property ($past(i_rd) &&
    ($past(i_addr) == `SCR_OFF_RSVD_A || $past(i_addr) == `SCR_OFF_RSVD_D)
    |-> o_rdata == 8'h00) else $error("reserved read not zero");
  a_mid_short: assert property (o_mon.mid_short_en == (m == 3'h1))
    else $error("mid-supply short wrong");
  a_temp_route: assert property (o_mon.temp_sense_en == (m == 3'h2))
    else $error("temperature route wrong");
  a_gain_force: assert property (
    o_mon.gain_force_one == (m == 3'h3 || m == 3'h4))
    else $error("gain force wrong");
  a_burnout_lvl: assert property (o_mon.burnout_level ==
    (m == 3'h5 ? 2'h1 : m == 3'h6 ? 2'h2 : 2'h0))
    else $error("burn-out level wrong");
  a_mux_open: assert property (
    o_mon.mux_open == (m inside {[3'h1:3'h4]}))
    else $error("input switches wrong");
  a_samp_count: assert property (o_calib_samples ==
    (c == 2'h0 ? 5'h01 : c == 2'h1 ? 5'h04 : c == 2'h2 ? 5'h08 : 5'h10))
    else $error("sample count wrong");
  a_cfg_hold: assert property (!$past(i_conv_start) |-> $stable(o_cfg))
    else $error("settings changed without start");
  a_reset_vals: assert property ($rose(i_rstn) |->
    o_cal == 32'h00004000 && o_cfg == 6'h04)
    else $error("reset values wrong");

  c_force: cover property (o_mon.gain_force_one);
  c_burn_hi: cover property (o_mon.burnout_level == 2'h2);
  c_rsvd_rd: cover property ($past(i_rd) && $past(i_addr) == `SCR_OFF_RSVD_D);
endmodule : scr_regs_monitor

bind scr_regs scr_regs_monitor u_chk (.i_clk_sys(i_clk_sys),
  .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_conv_start(i_conv_start),
  .i_gain_code(i_gain_code), .i_amp_enabled(i_amp_enabled),
  .o_cfg(o_cfg), .o_mon(o_mon), .o_calib_samples(o_calib_samples),
  .o_cal(o_cal));
`default_nettype wire

// >>> bench/testbench.sv
// Self-checking bench for the control and calibration bank
`timescale 1ns/1ns
`default_nettype none
`include "scr_cfg.svh"
`define CHK(n, e, s) begin \
  total_checks++; \
  if ((s) !== (e)) begin \
    mismatches++; \
    $display("wrong value %s expected %h seen %h", n, e, s); \
  end \
end
module testbench
  import scr_pkg::*;
;
  logic               i_clk_sys = 1'b0;
  logic               i_rstn = 1'b0;
  logic [`SCR_AW-1:0] i_addr = 5'h00;
  logic [7:0]         i_wdata = 8'h00;
  logic               i_wr = 1'b0;
  logic               i_rd = 1'b0;
  logic               i_conv_start = 1'b0;
  logic [2:0]         i_gain_code = 3'h0;
  logic               i_amp_enabled = 1'b1;
  logic [7:0]         o_rdata;
  scr_cfg_t           o_cfg;
  scr_mon_t           o_mon;
  logic [4:0]         o_calib_samples;
  scr_cal_t           o_cal;
  int                 mismatches = 0;
  int                 total_checks = 0;
  int                 seed = 32'h9CBD;
  int                 k;
  int                 m;
  logic [7:0]         rq[$];
  logic               rd_d = 1'b0;
  logic [7:0]         ev, v, lo, hi;
  logic [4:0]         al;
  logic [15:0]        cv;
  scr_cfg_t           pc = 6'h04;
  scr_mon_t           em;
  logic [7:0]         rv[7] = '{8'h10, 8'h00, 8'h00, 8'h00,
                                8'h00, 8'h00, 8'h40};
  logic [4:0]         sv[4] = '{5'h01, 5'h04, 5'h08, 5'h10};

  always #4 i_clk_sys = ~i_clk_sys;

  scr_regs dut (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_conv_start(i_conv_start), .i_gain_code(i_gain_code),
    .i_amp_enabled(i_amp_enabled), .o_cfg(o_cfg), .o_mon(o_mon),
    .o_calib_samples(o_calib_samples), .o_cal(o_cal));

  // ----------------------------------------
  // Read data watcher
  // ----------------------------------------
  always @(posedge i_clk_sys) rd_d <= i_rd;
  always @(negedge i_clk_sys) begin
    if (rd_d) begin
      ev = rq.pop_front();
      `CHK("rdata", ev, o_rdata)
    end
  end

  task op(input logic w, r, c, input logic [4:0] a, input logic [7:0] d);
    i_wr <= w;
    i_rd <= r;
    i_conv_start <= c;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
  endtask : op
  task wr(input logic [4:0] a, input logic [7:0] d);
    op(1'b1, 1'b0, 1'b0, a, d);
  endtask : wr
  task rd(input logic [4:0] a, input logic [7:0] e);
    rq.push_back(e);
    op(1'b0, 1'b1, 1'b0, a, 8'h00);
  endtask : rd
  task idle(input logic c);
    op(1'b0, 1'b0, c, 5'h00, 8'h00);
  endtask : idle
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (5000) @(posedge i_clk_sys);
    mismatches++;
    end_of_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    for (k = 0; k < 7; k++) rd(5'h09 + k[4:0], rv[k]);
    rd(5'h15, 8'h00);
    v = 8'($random(seed)) | 8'h01;
    wr(`SCR_OFF_RSVD_A, v);
    wr(`SCR_OFF_RSVD_D, v);
    rd(`SCR_OFF_RSVD_A, 8'h00);
    rd(`SCR_OFF_RSVD_D, 8'h00);
    rd(`SCR_OFF_STATUS, 8'h01);
    rd(`SCR_OFF_STATUS, 8'h00);
    for (k = 0; k < 2; k++) begin
      lo = 8'($random(seed));
      hi = 8'($random(seed));
      al = k ? `SCR_OFF_GAIN_LO : `SCR_OFF_OFS_LO;
      wr(al, lo);
      idle(1'b0);
      idle(1'b0);
      @(negedge i_clk_sys);
      cv = k ? o_cal.gain_correction_value : o_cal.offset_correction_value;
      `CHK("cal half", k ? 16'h4000 : 16'h0000, cv)
      @(posedge i_clk_sys);
      wr(al + 5'h01, hi);
      idle(1'b0);
      idle(1'b0);
      @(negedge i_clk_sys);
      cv = k ? o_cal.gain_correction_value : o_cal.offset_correction_value;
      `CHK("cal", {hi, lo}, cv)
      @(posedge i_clk_sys);
      rd(al, lo);
      rd(al + 5'h01, hi);
    end
    for (m = 0; m < 8; m++) begin
      v = {m[2:0], m[1:0], m[0], 2'b00};
      i_gain_code <= 3'($random(seed));
      i_amp_enabled <= 1'($random(seed));
      wr(`SCR_OFF_SYSCTL, v);
      idle(1'b0);
      @(negedge i_clk_sys);
      `CHK("cfg held", pc, o_cfg)
      @(posedge i_clk_sys);
      idle(1'b1);
      idle(1'b0);
      idle(1'b0);
      @(negedge i_clk_sys);
      pc = v[7:2];
      em = {m inside {[1:4]}, m == 3 || m == 4, m == 2, m == 1,
        m == 5 ? 2'h1 : m == 6 ? 2'h2 : 2'h0,
        m == 2 && (!i_amp_enabled || i_gain_code > 3'h2)};
      `CHK("cfg", pc, o_cfg)
      `CHK("mon", em, o_mon)
      `CHK("samples", sv[m % 4], o_calib_samples)
      @(posedge i_clk_sys);
      rd(`SCR_OFF_SYSCTL, v);
      rd(`SCR_OFF_STATUS, {6'h00, em.temp_gain_bad, 1'b0});
    end
    idle(1'b0);
    idle(1'b0);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
